// ===== core/rdm_defines.vh
// Purpose: Constants for the regulator discharge and mode-0 register block
// Assumes: Register addresses are I2C sub-addresses (pointer byte values)
// Notes:   Field positions, reset values and voltage decode figures
`ifndef RDM_DEFINES_VH
`define RDM_DEFINES_VH

// Register addresses
`define RDM_ADDR_DISCHARGE    8'h21
`define RDM_ADDR_MODE0_CFG0   8'h22

// Discharge-control fields
`define RDM_DISCH_CORE_BUCK   3
`define RDM_DISCH_SYS_BUCK    2
`define RDM_DISCH_AON_LDO     1
`define RDM_DISCH_SYS_LDO     0
`define RDM_DISCH_RESET       8'h00

// Mode-0 configuration fields
`define RDM_MODE0_SHIP        7
`define RDM_MODE0_SRC         6
`define RDM_MODE0_CODE_MSB    5
`define RDM_MODE0_CODE_LSB    0
`define RDM_MODE0_SHIP_RESET  1'h0
`define RDM_MODE0_SRC_RESET   1'h0
`define RDM_MODE0_CODE_RESET  6'h14

// Core buck voltage decode, millivolts
`define RDM_MV_BASE           11'h1f4
`define RDM_MV_STEP           11'h019
`define RDM_CODE_LINEAR_MAX   6'h28
`define RDM_CODE_FIXED        6'h3f
`define RDM_MV_CLAMP          11'h5dc
`define RDM_MV_FIXED          11'h708
`define RDM_MV_RESET          11'h3e8

// I2C target address, value arbitrary
`define RDM_DEV_ADDR_DEFAULT  7'h2a
`define RDM_DATA_UNMAPPED     8'h00

`endif

// ===== core/rdm_sync.v
// Purpose: Two-flip-flop synchroniser, one stage pair per bit
// Assumes: Each bit is an independent level
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ns
module rdm_sync #(
  parameter             WIDTH   = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             sys_clk_in,
  input  wire             rst_in,
  // Asynchronous levels
  input  wire [WIDTH-1:0] async_in,
  // Synchronised levels
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          meta_r <= RST_VAL[i];
          sync_r <= RST_VAL[i];
        end else begin
          meta_r <= async_in[i];
          sync_r <= meta_r;
        end
      end
      assign sync_out[i] = sync_r;
    end
  endgenerate

endmodule

// ===== core/rdm_top.v
// Purpose: I2C target with discharge-control and mode-0 configuration registers
// Assumes: SCL well below a tenth of the 100 MHz system clock
// Notes:   Pointer auto-increments after each data byte; unmapped reads give zero
`timescale 1ns/1ns
`include "rdm_defines.vh"
module rdm_top #(
  parameter [6:0] DEV_ADDR = `RDM_DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_in,
  // I2C target pins
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_out,
  // Nonvolatile trim defaults
  input  wire        trim_mode_source_in,
  input  wire [5:0]  trim_core_code_in,
  // Regulator enable state
  input  wire        core_buck_enabled_in,
  input  wire        system_buck_enabled_in,
  input  wire        always_on_ldo_enabled_in,
  input  wire        system_ldo_enabled_in,
  input  wire        mode0_active_in,
  // Mode select sources
  input  wire        mode_select_pin_a_in,
  input  wire        mode_select_pin_b_in,
  input  wire        mode_select_reg_bit_a_in,
  input  wire        mode_select_reg_bit_b_in,
  // Discharge resistor controls
  output wire        core_buck_discharge_on_out,
  output wire        system_buck_discharge_on_out,
  output wire        always_on_ldo_discharge_on_out,
  output wire        system_ldo_discharge_on_out,
  // Mode-0 results
  output wire        ship_mode_out,
  output wire        mode_select_a_out,
  output wire        mode_select_b_out,
  output wire [5:0]  core_buck_voltage_code_out,
  output wire [10:0] core_buck_millivolt_out
);

  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_ADDR  = 4'h1;
  localparam [3:0] S_PTR   = 4'h2;
  localparam [3:0] S_WDATA = 4'h3;
  localparam [3:0] S_ACK   = 4'h4;
  localparam [3:0] S_RDATA = 4'h5;
  localparam [3:0] S_RACK  = 4'h6;

  wire [3:0] sync_w;
  wire       scl_s;
  wire       sda_s;
  wire       pin_a_s;
  wire       pin_b_s;

  reg        scl_d_r;
  reg        sda_d_r;
  reg [3:0]  state_r;
  reg [3:0]  state_nxt;
  reg [3:0]  ret_r;
  reg [3:0]  ret_nxt;
  reg [2:0]  bit_cnt_r;
  reg [2:0]  bit_cnt_nxt;
  reg [7:0]  shift_r;
  reg [7:0]  shift_nxt;
  reg [7:0]  ptr_r;
  reg [7:0]  ptr_nxt;
  reg        ack_drv_r;
  reg        ack_drv_nxt;
  reg        got_ack_r;
  reg        got_ack_nxt;
  reg        sda_oe_r;
  reg        sda_oe_nxt;
  reg [7:0]  disch_r;
  reg [7:0]  disch_nxt;
  reg [7:0]  mode0_r;
  reg [7:0]  mode0_nxt;
  reg        trim_load_r;
  reg [7:0]  rd_data;
  reg [7:0]  rx_byte;
  reg [3:0]  disch_on_r;
  reg        ship_r;
  reg        sel_a_r;
  reg        sel_b_r;
  reg [5:0]  code_r;
  reg [10:0] mv_r;
  reg [10:0] mv_nxt;

  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire [3:0] reg_enabled;
  wire [5:0] code_w;

  // Pins into the clock domain
  rdm_sync #(
    .WIDTH   (4),
    .RST_VAL (4'h3)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   ({mode_select_pin_b_in, mode_select_pin_a_in, sda_in, scl_in}),
    .sync_out   (sync_w)
  );

  assign scl_s   = sync_w[0];
  assign sda_s   = sync_w[1];
  assign pin_a_s = sync_w[2];
  assign pin_b_s = sync_w[3];

  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  always @* begin
    rx_byte = {shift_r[6:0], sda_s};
  end

  always @* begin
    case (ptr_r)
      `RDM_ADDR_DISCHARGE:  rd_data = disch_r;
      `RDM_ADDR_MODE0_CFG0: rd_data = mode0_r;
      default:              rd_data = `RDM_DATA_UNMAPPED;
    endcase
  end

  always @* begin
    state_nxt   = state_r;
    ret_nxt     = ret_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    ptr_nxt     = ptr_r;
    ack_drv_nxt = ack_drv_r;
    got_ack_nxt = got_ack_r;
    sda_oe_nxt  = sda_oe_r;
    disch_nxt   = disch_r;
    mode0_nxt   = mode0_r;
    if (stop_det) begin
      state_nxt  = S_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt   = S_ADDR;
      bit_cnt_nxt = 3'h0;
      sda_oe_nxt  = 1'b0;
      ack_drv_nxt = 1'b0;
      got_ack_nxt = 1'b0;
    end else begin
      case (state_r)
        S_ADDR, S_PTR, S_WDATA: begin
          if (scl_rise) begin
            shift_nxt   = rx_byte;
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              state_nxt = S_ACK;
              case (state_r)
                S_ADDR: begin
                  if (shift_r[6:0] != DEV_ADDR) begin
                    state_nxt = S_IDLE;
                  end else if (sda_s) begin
                    ret_nxt = S_RDATA;
                  end else begin
                    ret_nxt = S_PTR;
                  end
                end
                S_PTR: begin
                  ptr_nxt = rx_byte;
                  ret_nxt = S_WDATA;
                end
                default: begin
                  if (ptr_r == `RDM_ADDR_DISCHARGE) begin
                    disch_nxt = rx_byte;
                  end else if (ptr_r == `RDM_ADDR_MODE0_CFG0) begin
                    mode0_nxt = rx_byte;
                  end
                  ptr_nxt = ptr_r + 8'h01;
                  ret_nxt = S_WDATA;
                end
              endcase
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (!ack_drv_r) begin
              ack_drv_nxt = 1'b1;
              sda_oe_nxt  = 1'b1;
            end else begin
              ack_drv_nxt = 1'b0;
              bit_cnt_nxt = 3'h0;
              state_nxt   = ret_r;
              if (ret_r == S_RDATA) begin
                shift_nxt  = rd_data;
                sda_oe_nxt = ~rd_data[7];
              end else begin
                sda_oe_nxt = 1'b0;
              end
            end
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            shift_nxt  = {shift_r[6:0], 1'b0};
            sda_oe_nxt = ~shift_r[6];
          end else if (scl_rise) begin
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              state_nxt   = S_RACK;
              got_ack_nxt = 1'b0;
              ptr_nxt     = ptr_r + 8'h01;
            end
          end
        end
        S_RACK: begin
          if (scl_fall) begin
            if (got_ack_r) begin
              got_ack_nxt = 1'b0;
              state_nxt   = S_RDATA;
              shift_nxt   = rd_data;
              sda_oe_nxt  = ~rd_data[7];
            end else begin
              sda_oe_nxt = 1'b0;
            end
          end else if (scl_rise) begin
            if (sda_s) begin
              state_nxt = S_IDLE;
            end else begin
              got_ack_nxt = 1'b1;
            end
          end
        end
        default: begin
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
    if (trim_load_r) begin
      mode0_nxt[`RDM_MODE0_SRC] = trim_mode_source_in;
      mode0_nxt[`RDM_MODE0_CODE_MSB:`RDM_MODE0_CODE_LSB] = trim_core_code_in;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_d_r     <= 1'b1;
      sda_d_r     <= 1'b1;
      state_r     <= S_IDLE;
      ret_r       <= S_IDLE;
      bit_cnt_r   <= 3'h0;
      shift_r     <= 8'h00;
      ptr_r       <= 8'h00;
      ack_drv_r   <= 1'b0;
      got_ack_r   <= 1'b0;
      sda_oe_r    <= 1'b0;
      trim_load_r <= 1'b1;
      disch_r     <= `RDM_DISCH_RESET;
      mode0_r     <= {`RDM_MODE0_SHIP_RESET, `RDM_MODE0_SRC_RESET, `RDM_MODE0_CODE_RESET};
    end else begin
      scl_d_r     <= scl_s;
      sda_d_r     <= sda_s;
      state_r     <= state_nxt;
      ret_r       <= ret_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
      shift_r     <= shift_nxt;
      ptr_r       <= ptr_nxt;
      ack_drv_r   <= ack_drv_nxt;
      got_ack_r   <= got_ack_nxt;
      sda_oe_r    <= sda_oe_nxt;
      trim_load_r <= 1'b0;
      disch_r     <= disch_nxt;
      mode0_r     <= mode0_nxt;
    end
  end

  // Discharge on when bit clear and regulator off
  assign reg_enabled = {core_buck_enabled_in, system_buck_enabled_in,
                        always_on_ldo_enabled_in, system_ldo_enabled_in};

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_disch
      always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          disch_on_r[i] <= 1'b0;
        end else begin
          disch_on_r[i] <= ~disch_r[i] & ~reg_enabled[i];
        end
      end
    end
  endgenerate

  assign code_w = mode0_r[`RDM_MODE0_CODE_MSB:`RDM_MODE0_CODE_LSB];

  always @* begin
    if (code_w == `RDM_CODE_FIXED) begin
      mv_nxt = `RDM_MV_FIXED;
    end else if (code_w > `RDM_CODE_LINEAR_MAX) begin
      mv_nxt = `RDM_MV_CLAMP;
    end else begin
      mv_nxt = `RDM_MV_BASE + {5'h00, code_w} * `RDM_MV_STEP;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ship_r  <= 1'b0;
      sel_a_r <= 1'b0;
      sel_b_r <= 1'b0;
      code_r  <= `RDM_MODE0_CODE_RESET;
      mv_r    <= `RDM_MV_RESET;
    end else begin
      ship_r <= mode0_active_in & mode0_r[`RDM_MODE0_SHIP];
      if (mode0_r[`RDM_MODE0_SRC]) begin
        sel_a_r <= pin_a_s;
        sel_b_r <= pin_b_s;
      end else begin
        sel_a_r <= mode_select_reg_bit_a_in;
        sel_b_r <= mode_select_reg_bit_b_in;
      end
      code_r <= code_w;
      mv_r   <= mv_nxt;
    end
  end

  assign sda_out                        = 1'b0;
  assign sda_oe_out                     = sda_oe_r;
  assign core_buck_discharge_on_out     = disch_on_r[`RDM_DISCH_CORE_BUCK];
  assign system_buck_discharge_on_out   = disch_on_r[`RDM_DISCH_SYS_BUCK];
  assign always_on_ldo_discharge_on_out = disch_on_r[`RDM_DISCH_AON_LDO];
  assign system_ldo_discharge_on_out    = disch_on_r[`RDM_DISCH_SYS_LDO];
  assign ship_mode_out                  = ship_r;
  assign mode_select_a_out              = sel_a_r;
  assign mode_select_b_out              = sel_b_r;
  assign core_buck_voltage_code_out     = code_r;
  assign core_buck_millivolt_out        = mv_r;

endmodule

// ===== dv/rdm_top_properties.sv
// Purpose: Port assertions for rdm_top
// Assumes: One clock domain, async active-high reset
// Notes:   Bound to every rdm_top instance
`timescale 1ns/1ns
module rdm_props_chk (
  // Clock and reset
  input logic        sys_clk_in,
  input logic        rst_in,
  // Watched inputs
  input logic [5:0]  trim_core_code_in,
  input logic        core_buck_enabled_in,
  input logic        system_buck_enabled_in,
  input logic        always_on_ldo_enabled_in,
  input logic        system_ldo_enabled_in,
  input logic        mode0_active_in,
  input logic        mode_select_pin_a_in,
  input logic        mode_select_reg_bit_a_in,
  // Watched outputs
  input logic        core_buck_discharge_on_out,
  input logic        system_buck_discharge_on_out,
  input logic        always_on_ldo_discharge_on_out,
  input logic        system_ldo_discharge_on_out,
  input logic        ship_mode_out,
  input logic        mode_select_a_out,
  input logic [5:0]  core_buck_voltage_code_out,
  input logic [10:0] core_buck_millivolt_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  a_core_buck_gate: assert property ($past(core_buck_enabled_in) |-> !core_buck_discharge_on_out)
    else $error("core buck discharge on while enabled");
  a_sys_buck_gate: assert property ($past(system_buck_enabled_in) |-> !system_buck_discharge_on_out)
    else $error("system buck discharge on while enabled");
  a_aon_ldo_gate: assert property ($past(always_on_ldo_enabled_in) |-> !always_on_ldo_discharge_on_out)
    else $error("always-on ldo discharge on while enabled");
  a_sys_ldo_gate: assert property ($past(system_ldo_enabled_in) |-> !system_ldo_discharge_on_out)
    else $error("system ldo discharge on while enabled");
  a_ship_needs_mode0: assert property (ship_mode_out |-> $past(mode0_active_in))
    else $error("ship mode outside mode setting 0");
  a_mode_src_one: assert property (mode_select_a_out == $past(mode_select_reg_bit_a_in) ||
    mode_select_a_out == $past(mode_select_pin_a_in, 3)) else $error("mode select from no source");
  a_code_reset_val: assert property ($fell(rst_in) |-> core_buck_voltage_code_out == 6'h14 &&
    core_buck_millivolt_out == 11'h3e8) else $error("core code reset value wrong");
  a_code_trim_load: assert property ($fell(rst_in) |-> ##2 core_buck_voltage_code_out == trim_core_code_in)
    else $error("core code not loaded from trim");
  a_mv_linear_map: assert property (core_buck_voltage_code_out <= 6'h28 |->
    core_buck_millivolt_out == 11'h1f4 + 11'h019 * core_buck_voltage_code_out) else $error("linear decode wrong");
  a_mv_top_codes: assert property (core_buck_voltage_code_out > 6'h28 |->
    core_buck_millivolt_out == (core_buck_voltage_code_out == 6'h3f ? 11'h708 : 11'h5dc)) else $error("clamp wrong");

  c_ship: cover property (ship_mode_out);
  c_discharge: cover property (core_buck_discharge_on_out);
  c_fixed_code: cover property (core_buck_voltage_code_out == 6'h3f);
endmodule

bind rdm_top rdm_props_chk u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .trim_core_code_in(trim_core_code_in),
  .core_buck_enabled_in(core_buck_enabled_in), .system_buck_enabled_in(system_buck_enabled_in),
  .always_on_ldo_enabled_in(always_on_ldo_enabled_in), .system_ldo_enabled_in(system_ldo_enabled_in),
  .mode0_active_in(mode0_active_in), .mode_select_pin_a_in(mode_select_pin_a_in),
  .mode_select_reg_bit_a_in(mode_select_reg_bit_a_in), .core_buck_discharge_on_out(core_buck_discharge_on_out),
  .system_buck_discharge_on_out(system_buck_discharge_on_out),
  .always_on_ldo_discharge_on_out(always_on_ldo_discharge_on_out),
  .system_ldo_discharge_on_out(system_ldo_discharge_on_out), .ship_mode_out(ship_mode_out),
  .mode_select_a_out(mode_select_a_out), .core_buck_voltage_code_out(core_buck_voltage_code_out),
  .core_buck_millivolt_out(core_buck_millivolt_out)
);

// ===== dv/rdm_i2c_host.sv
// Purpose: I2C host model for the register bus
// Assumes: Pull-up on SDA modelled in the bench
// Notes:   One SCL phase is 10 system clocks
`timescale 1ns/1ns
module rdm_i2c_host #(
  parameter [6:0] DEV_ADDR = 7'h2a
) (
  // Clock
  input  wire  sys_clk_in,
  // Bus lines
  input  wire  sda_line_in,
  output logic scl_out,
  output logic sda_pull_out
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  // SDA moves only while SCL low
  task automatic bitx(input logic d, output logic r);
    scl_out <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    sda_pull_out <= ~d;
    repeat (5) @(posedge sys_clk_in);
    scl_out <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    r = sda_line_in;
    repeat (5) @(posedge sys_clk_in);
  endtask

  task automatic start_c;
    logic r;
    bitx(1'b1, r);
    sda_pull_out <= 1'b1;
    repeat (10) @(posedge sys_clk_in);
  endtask

  task automatic stop_c;
    logic r;
    bitx(1'b0, r);
    sda_pull_out <= 1'b0;
    repeat (10) @(posedge sys_clk_in);
  endtask

  // Byte MSB first, host releases in ack slot
  task automatic xfer(input logic [7:0] v, output logic [7:0] rv, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(v[i], rv[i]);
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask

  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] data, output logic [2:0] ok);
    logic [7:0] rv;
    start_c();
    xfer({DEV_ADDR, 1'b0}, rv, ok[2]);
    xfer(ptr, rv, ok[1]);
    xfer(data, rv, ok[0]);
    stop_c();
  endtask

  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] data, output logic [2:0] ok);
    logic a;
    start_c();
    xfer({DEV_ADDR, 1'h0}, data, ok[2]);
    xfer(ptr, data, ok[1]);
    start_c();
    xfer({DEV_ADDR, 1'h1}, data, ok[0]);
    xfer(8'hff, data, a);
    stop_c();
  endtask

  // Two-byte read, host ACKs the first byte
  task automatic rd_pair(input logic [7:0] ptr, output logic [15:0] data, output logic [2:0] ok);
    logic r;
    start_c();
    xfer({DEV_ADDR, 1'h0}, data[7:0], ok[2]);
    xfer(ptr, data[7:0], ok[1]);
    start_c();
    xfer({DEV_ADDR, 1'h1}, data[7:0], ok[0]);
    for (int i = 15; i >= 8; i--) begin
      bitx(1'h1, data[i]);
    end
    bitx(1'h0, r);
    xfer(8'hff, data[7:0], r);
    stop_c();
  endtask

  // Address phase only, to a chosen target address
  task automatic probe(input logic [6:0] dev, output logic ack);
    logic [7:0] rv;
    start_c();
    xfer({dev, 1'h0}, rv, ack);
    stop_c();
  endtask
endmodule

// ===== dv/test_regulator_discharge_mode0_cfg.sv
// Purpose: Self-checking bench for rdm_top
// Assumes: Host model drives SCL and SDA
// Notes:   Trim code set away from 0x14 to see the load
`timescale 1ns/1ns
module test_regulator_discharge_mode0_cfg;
  logic        sys_clk_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic        trim_src   = 1'b1;
  logic        act        = 1'b0;
  logic [5:0]  trim_code  = 6'h21;
  logic [3:0]  en         = 4'h0;
  logic [1:0]  pins       = 2'h0;
  logic [1:0]  rbits      = 2'h0;
  logic [7:0]  v;
  logic [2:0]  ok;
  wire         scl;
  wire         pull;
  wire         sda_oe;
  wire         sda_o;
  // Open drain with pull-up
  wire         sda_line   = ~pull & (~sda_oe | sda_o);
  wire  [3:0]  dis;
  wire         ship;
  wire  [1:0]  sel;
  wire  [5:0]  code;
  wire  [10:0] mv;
  int          failures   = 0;
  int          compares   = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  rdm_top DUT (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .trim_mode_source_in(trim_src), .trim_core_code_in(trim_code), .core_buck_enabled_in(en[3]),
    .system_buck_enabled_in(en[2]), .always_on_ldo_enabled_in(en[1]), .system_ldo_enabled_in(en[0]),
    .mode0_active_in(act), .mode_select_pin_a_in(pins[1]), .mode_select_pin_b_in(pins[0]),
    .mode_select_reg_bit_a_in(rbits[1]), .mode_select_reg_bit_b_in(rbits[0]),
    .core_buck_discharge_on_out(dis[3]), .system_buck_discharge_on_out(dis[2]),
    .always_on_ldo_discharge_on_out(dis[1]), .system_ldo_discharge_on_out(dis[0]),
    .ship_mode_out(ship), .mode_select_a_out(sel[1]), .mode_select_b_out(sel[0]),
    .core_buck_voltage_code_out(code), .core_buck_millivolt_out(mv)
  );

  rdm_i2c_host u_host (.sys_clk_in(sys_clk_in), .sda_line_in(sda_line), .scl_out(scl), .sda_pull_out(pull));

  task automatic chk(input string name, input logic [10:0] seen, input logic [10:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.wr_reg(a, d, ok);
    chk("write ack", {8'h00, ok}, 11'h007);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    u_host.rd_reg(a, v, ok);
    chk("read ack", {8'h00, ok}, 11'h007);
    chk(name, {3'h0, v}, {3'h0, exp});
  endtask

  task automatic settle;
    repeat (4) @(posedge sys_clk_in);
  endtask

  task automatic t_reset;
    logic a;
    rd_chk("discharge reset", 8'h21, 8'h00);
    rd_chk("mode0 reset", 8'h22, 8'h61);
    chk("code out", {5'h00, code}, 11'h021);
    chk("millivolt trim", mv, 11'h52d);
    chk("ship reset", {10'h000, ship}, 11'h000);
    chk("discharge idle", {7'h00, dis}, 11'h00f);
    wr(8'h30, 8'h5a);
    rd_chk("unmapped", 8'h30, 8'h00);
    u_host.probe(7'h55, a);
    chk("foreign address ack", {10'h000, a}, 11'h000);
  endtask

  task automatic disch_step(input logic [7:0] p);
    wr(8'h21, p);
    rd_chk("discharge rw", 8'h21, p);
    chk("discharge off", {7'h00, dis}, {7'h00, ~p[3:0]});
    @(posedge sys_clk_in) en <= 4'h6;
    settle();
    chk("discharge partial", {7'h00, dis}, {7'h00, ~p[3:0] & 4'h9});
    @(posedge sys_clk_in) en <= 4'hf;
    settle();
    chk("discharge enabled", {7'h00, dis}, 11'h000);
    @(posedge sys_clk_in) en <= 4'h0;
    settle();
  endtask

  task automatic t_disch;
    disch_step(8'ha5);
    disch_step(8'h5a);
  endtask

  task automatic t_mode;
    @(posedge sys_clk_in) act <= 1'h1;
    @(posedge sys_clk_in) pins <= 2'h2;
    @(posedge sys_clk_in) rbits <= 2'h1;
    wr(8'h22, 8'hd4);
    settle();
    chk("ship on", {10'h000, ship}, 11'h001);
    chk("select pins", {9'h000, sel}, 11'h002);
    @(posedge sys_clk_in) pins <= 2'h1;
    settle();
    chk("select pins", {9'h000, sel}, 11'h001);
    @(posedge sys_clk_in) act <= 1'h0;
    settle();
    chk("ship idle", {10'h000, ship}, 11'h000);
    @(posedge sys_clk_in) rbits <= 2'h2;
    wr(8'h22, 8'h14);
    @(posedge sys_clk_in) act <= 1'h1;
    settle();
    chk("select bits", {9'h000, sel}, 11'h002);
    chk("ship cleared", {10'h000, ship}, 11'h000);
  endtask

  task automatic code_step(input logic [5:0] c, input logic [10:0] m);
    wr(8'h22, {2'h0, c});
    settle();
    chk("code out", {5'h00, code}, {5'h00, c});
    chk("millivolt", mv, m);
  endtask

  task automatic t_codes;
    logic [15:0] pr;
    code_step(6'h00, 11'h1f4);
    code_step(6'h15, 11'h401);
    code_step(6'h28, 11'h5dc);
    code_step(6'h29, 11'h5dc);
    code_step(6'h3e, 11'h5dc);
    code_step(6'h3f, 11'h708);
    rd_chk("mode0 rw", 8'h22, 8'h3f);
    u_host.rd_pair(8'h21, pr, ok);
    chk("pair ack", {8'h00, ok}, 11'h007);
    chk("pair first", {3'h0, pr[15:8]}, 11'h05a);
    chk("pair second", {3'h0, pr[7:0]}, 11'h03f);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    t_reset();
    t_disch();
    t_mode();
    t_codes();
    finish_test();
  end

  initial begin
    #600000;
    failures++;
    finish_test();
  end
endmodule
